// ### src/etsf_pkg.sv
// Constants and types shared by the telegram framer and its status keeper
package etsf_pkg;

    // Clock and millisecond timing
    localparam int ETSF_CLK_MHZ = 250; // System clock rate in MHz
    localparam int ETSF_MS_NS = 1000000; // One millisecond in ns
    localparam int ETSF_MS_CYCLES = ETSF_MS_NS * ETSF_CLK_MHZ / 1000; // Cycles per ms
    localparam int ETSF_MS_W = 18; // Width of the millisecond divider

    // Identifier table: index, width and fallback values
    localparam int ETSF_ID_W = 11; // Standard identifier width
    localparam int ETSF_NUM_ID = 6; // Three receive, three transmit
    localparam int ETSF_IX_REQ = 0; // Position request, receive
    localparam int ETSF_IX_SYNC = 1; // Sync, receive
    localparam int ETSF_IX_PAR = 2; // Set parameter, receive
    localparam int ETSF_IX_REP = 3; // Position reply, transmit
    localparam int ETSF_IX_CYC = 4; // Cyclic position, transmit
    localparam int ETSF_IX_PREP = 5; // Parameter reply, transmit
    localparam logic [10:0] ETSF_ID_DEF [ETSF_NUM_ID] = '{
        11'h200, 11'h100, 11'h300, 11'h280, 11'h180, 11'h380
    };

    // Function select codes
    localparam logic [7:0] ETSF_FSC_POS = 8'h00; // Position request and reply
    localparam logic [7:0] ETSF_FSC_CYC = 8'h30; // Cyclic position report
    localparam logic [7:0] ETSF_FSC_RESET = 8'h01; // Software reset
    localparam logic [7:0] ETSF_FSC_READ = 8'h02; // Read status
    localparam logic [7:0] ETSF_FSC_TIME = 8'h03; // Set cycle and sync time
    localparam logic [7:0] ETSF_FSC_CMD = 8'h04; // Write command byte
    localparam logic [7:0] ETSF_FSC_ID0 = 8'h10; // First identifier write code

    // Frame lengths, outgoing exact and incoming least
    localparam logic [3:0] ETSF_DLC_POS = 4'h6; // Code, status, four position bytes
    localparam logic [3:0] ETSF_DLC_PREP = 4'h2; // Code and status
    localparam logic [3:0] ETSF_DLC_MIN = 4'h1; // Code only
    localparam logic [3:0] ETSF_DLC_TIME = 4'h5; // Code and four time bytes
    localparam logic [3:0] ETSF_DLC_CMD = 4'h2; // Code and command byte
    localparam logic [3:0] ETSF_DLC_ID = 4'h3; // Code and two identifier bytes

    // Command byte fields
    localparam int ETSF_CMD_CYCLIC = 0; // Periodic reporting enable
    localparam int ETSF_CMD_SYNC = 1; // Sync operation enable

    // Reset values
    localparam logic [7:0] ETSF_CMD_RST = 8'h00; // Polled operation
    localparam logic [15:0] ETSF_CYC_RST = 16'h0064; // Cycle time in ms
    localparam logic [15:0] ETSF_SYNC_RST = 16'h03e8; // Sync time in ms

    // Register offsets
    localparam logic [7:0] ETSF_REG_STATUS = 8'h00; // Status byte, read only
    localparam logic [7:0] ETSF_REG_CTRL = 8'h04; // Command byte, running flag
    localparam logic [7:0] ETSF_REG_CYC = 8'h08; // Cycle time in ms
    localparam logic [7:0] ETSF_REG_SYNC = 8'h0c; // Sync time in ms
    localparam logic [7:0] ETSF_REG_ID0 = 8'h10; // First identifier word

    // Transmit slot state
    typedef enum logic [0:0] {
        ETSF_TX_IDLE = 1'b0,
        ETSF_TX_HOLD = 1'b1
    } etsf_tx_t;

endpackage

// ### src/etsf_status.sv
// Status byte keeper: sticky error flags, busy flag and mode bits
`timescale 1ns/1ps
module etsf_status
    import etsf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] err_set, // Sync, param, pos, com event
    input wire logic [3:0] err_hold, // Cause still present
    input wire logic err_clear, // Read status pulse
    input wire logic busy_cause, // Position data in doubt
    input wire logic fallback, // Default identifiers and rate
    input wire logic periodic, // Cyclic reporting running
    input wire logic sync_on, // Sync operation selected
    output logic [7:0] status_byte
);
    logic [3:0] err; // Sticky errors
    logic [3:0] next_err;
    logic busy; // Busy flag
    logic next_busy;
    logic [2:0] mode; // Mode indicators
    logic [2:0] next_mode;

    // Next flags; a new event beats a clear in the same cycle
    always_comb begin
        next_err = err;
        // Clear keeps bits whose cause persists
        if (err_clear) begin
            next_err = err & err_hold; // RULE10 RULE11
        end
        next_err = next_err | err_set;
        next_busy = busy_cause; // RULE8 RULE9
        next_mode = {fallback, periodic, sync_on}; // RULE12 RULE13
    end

    // Flag registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err <= 4'h0;
            busy <= 1'b0;
            mode <= 3'h0;
        end else begin
            err <= next_err;
            busy <= next_busy;
            mode <= next_mode;
        end
    end

    // Bit 7 busy, 6..3 errors, 2..0 modes
    assign status_byte = {busy, err, mode}; // RULE7

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_set_wins: assert property ( // RULE11
        err_clear && err_set[0] |=> status_byte[3])
        else $error("Com error lost against a clear");
    a_clear_drops: assert property ( // RULE10
        err_clear && err_set == 4'h0 && err_hold == 4'h0 |=> status_byte[6:3] == 4'h0)
        else $error("Error bits not cleared by read status");
    a_busy_auto: assert property ( // RULE9
        busy_cause ##1 !busy_cause |=> !status_byte[7])
        else $error("Busy did not drop after data valid");
    c_clear: cover property (err_clear && status_byte[6:3] != 4'h0);
endmodule // etsf_status

// ### src/etsf_framer.sv
// Encoder telegram framer: decode, replies, identifiers, cyclic timing
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
// Function
// RULE1: Code in byte zero, data bytes follow
// RULE2: Decode each telegram by its function code
// RULE3: Frame length code sized per telegram type
// RULE4: Status byte goes in first data byte
// RULE5: Accept long frames, ignore extra bytes
// RULE6: Outgoing frames carry exactly needed bytes
// RULE7: Status bit order busy down to sync
// RULE8: Busy set while position data doubtful
// RULE9: Busy clears itself when data valid
// RULE10: Read status clears the four errors
// RULE11: Errors with live cause stay set
// RULE12: Fallback flag when defaults are used
// RULE13: Cyclic flag follows periodic reporting
// RULE14: Three receive, three transmit identifiers
// RULE15: Identifiers persisted and changeable by telegram
// RULE16: Sync timeout stops reports, sets error
// RULE17: Position sent low byte first
// RULE18: Undefined identifier uses its default
// RULE19: Controller error sets sticky com error
module etsf_framer
    import etsf_pkg::*;
#(
    parameter int MS_CYCLES = ETSF_MS_CYCLES // Cycles per ms, shorten in sims
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [10:0] rx_id,
    input wire logic [3:0] rx_dlc,
    input wire logic [63:0] rx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [10:0] tx_id,
    output logic [3:0] tx_dlc,
    output logic [63:0] tx_data,
    input wire logic [31:0] position,
    input wire logic position_fault,
    input wire logic can_error,
    input wire logic default_baud,
    input wire logic [65:0] nv_id,
    input wire logic [5:0] nv_defined,
    output logic nv_we,
    output logic [2:0] nv_index,
    output logic [10:0] nv_value,
    output logic [7:0] status_byte
);
    // Byte n of a frame payload
    function automatic logic [7:0] rx_byte(input logic [63:0] d, input int n);
        return d[n*8 +: 8];
    endfunction

    // Register address of identifier word i
    function automatic logic [7:0] id_addr(input int i);
        return ETSF_REG_ID0 + 8'(4 * i);
    endfunction

    etsf_tx_t tx_state; // Transmit slot
    etsf_tx_t next_tx_state;
    logic [10:0] next_tx_id;
    logic [3:0] next_tx_dlc;
    logic [63:0] next_tx_data;
    logic [7:0] cmd; // Command byte
    logic [7:0] next_cmd;
    logic [15:0] cyc_time; // Cycle time, ms
    logic [15:0] next_cyc_time;
    logic [15:0] sync_time; // Sync time, ms
    logic [15:0] next_sync_time;
    logic [10:0] id_val [ETSF_NUM_ID]; // Stored identifiers
    logic [10:0] next_id_val [ETSF_NUM_ID];
    logic [5:0] id_def; // Identifier defined
    logic [5:0] next_id_def;
    logic [10:0] eff_id [ETSF_NUM_ID]; // Identifier in use
    logic loaded; // Stored identifiers fetched
    logic next_nv_we;
    logic [2:0] next_nv_index;
    logic [10:0] next_nv_value;
    logic [ETSF_MS_W-1:0] ms_cnt; // Millisecond divider
    logic [ETSF_MS_W-1:0] next_ms_cnt;
    logic [15:0] cyc_cnt; // Ms into current cycle
    logic [15:0] next_cyc_cnt;
    logic [15:0] sync_cnt; // Ms since last sync
    logic [15:0] next_sync_cnt;
    logic running; // Periodic reporting active
    logic next_running;
    logic cyc_due; // Cyclic report waiting
    logic next_cyc_due;
    logic [31:0] next_rdata;
    logic ms_tick; // One-cycle ms enable
    logic sync_to; // Sync time ran out
    logic cyc_tick; // Cycle time reached
    logic rx_fire; // Frame taken this cycle
    logic hit_req; // Position request match
    logic hit_sync; // Sync match
    logic hit_par; // Set parameter match
    logic [7:0] function_select; // Incoming function select
    logic err_pos; // Bad request code
    logic err_par; // Bad parameter telegram
    logic err_clear; // Read status seen
    logic sw_reset; // Software reset seen
    logic sync_rx; // Sync telegram seen
    logic cyc_take; // Cyclic report loaded
    logic fallback; // All identifiers and the rate default

    // Identifier in use per slot
    for (genvar g = 0; g < ETSF_NUM_ID; g++) begin : g_eff
        assign eff_id[g] = id_def[g] ? id_val[g] : ETSF_ID_DEF[g]; // RULE18
    end

    // Frame intake; new frames wait while a reply is pending
    assign rx_ready = (tx_state == ETSF_TX_IDLE);
    assign rx_fire = rx_valid && rx_ready;
    assign function_select = rx_byte(rx_data, 0); // RULE1
    assign hit_req = rx_fire && rx_id == eff_id[ETSF_IX_REQ]; // RULE14
    assign hit_sync = rx_fire && rx_id == eff_id[ETSF_IX_SYNC];
    assign hit_par = rx_fire && rx_id == eff_id[ETSF_IX_PAR];
    assign fallback = (id_def == 6'h00) && default_baud; // RULE12

    // Telegram decode, reply building, configuration
    always_comb begin
        next_tx_state = tx_state;
        next_tx_id = tx_id;
        next_tx_dlc = tx_dlc;
        next_tx_data = tx_data;
        next_cmd = cmd;
        next_cyc_time = cyc_time;
        next_sync_time = sync_time;
        next_id_val = id_val;
        next_id_def = id_def;
        next_nv_we = 1'b0;
        next_nv_index = nv_index;
        next_nv_value = nv_value;
        err_pos = 1'b0;
        err_par = 1'b0;
        err_clear = 1'b0;
        sw_reset = 1'b0;
        sync_rx = 1'b0;
        cyc_take = 1'b0;
        // Fetch persisted identifiers once after reset
        if (!loaded) begin
            for (int i = 0; i < ETSF_NUM_ID; i++) begin
                next_id_val[i] = nv_id[i*ETSF_ID_W +: ETSF_ID_W]; // RULE15
                next_id_def[i] = nv_defined[i];
            end
        end
        // Software writes
        if (reg_we) begin
            case (reg_addr)
                ETSF_REG_CTRL: next_cmd = reg_wdata[7:0];
                ETSF_REG_CYC: next_cyc_time = reg_wdata[15:0];
                ETSF_REG_SYNC: next_sync_time = reg_wdata[15:0];
                default: ; // Identifiers below, others ignored
            endcase
            for (int i = 0; i < ETSF_NUM_ID; i++) begin
                if (reg_addr == id_addr(i)) begin
                    next_id_val[i] = reg_wdata[10:0];
                    next_id_def[i] = 1'b1;
                    next_nv_we = 1'b1; // RULE15
                    next_nv_index = 3'(i);
                    next_nv_value = reg_wdata[10:0];
                end
            end
        end
        // Far side took the pending frame
        if (tx_state == ETSF_TX_HOLD && tx_ready) begin
            next_tx_state = ETSF_TX_IDLE;
        end
        // Bytes beyond what a function reads are never looked at
        if (hit_req) begin
            if (function_select == ETSF_FSC_POS) begin // RULE2
                next_tx_state = ETSF_TX_HOLD;
                next_tx_id = eff_id[ETSF_IX_REP]; // RULE14
                next_tx_dlc = ETSF_DLC_POS; // RULE3 RULE6
                next_tx_data = {16'h0000, position, status_byte, ETSF_FSC_POS}; // RULE4 RULE17
            end else begin
                err_pos = 1'b1;
            end
        end else if (hit_sync) begin
            sync_rx = 1'b1;
        end else if (hit_par) begin
            case (function_select) // RULE2
                ETSF_FSC_RESET: sw_reset = 1'b1;
                ETSF_FSC_READ: err_clear = 1'b1; // RULE10
                ETSF_FSC_TIME: begin
                    if (rx_dlc >= ETSF_DLC_TIME) begin // RULE5
                        next_cyc_time = {rx_byte(rx_data, 2), rx_byte(rx_data, 1)};
                        next_sync_time = {rx_byte(rx_data, 4), rx_byte(rx_data, 3)};
                    end else begin
                        err_par = 1'b1;
                    end
                end
                ETSF_FSC_CMD: begin
                    if (rx_dlc >= ETSF_DLC_CMD) begin
                        next_cmd = rx_byte(rx_data, 1);
                    end else begin
                        err_par = 1'b1;
                    end
                end
                default: begin
                    // Identifier write codes, one per slot
                    err_par = 1'b1;
                    for (int i = 0; i < ETSF_NUM_ID; i++) begin
                        if (function_select == ETSF_FSC_ID0 + 8'(i) && rx_dlc >= ETSF_DLC_ID) begin
                            err_par = 1'b0;
                            next_id_val[i] = {rx_data[18:16], rx_byte(rx_data, 1)};
                            next_id_def[i] = 1'b1;
                            next_nv_we = 1'b1; // RULE15
                            next_nv_index = 3'(i);
                            next_nv_value = next_id_val[i];
                        end
                    end
                end
            endcase
            // Reset restores the working settings and sends nothing
            if (sw_reset) begin
                next_cmd = ETSF_CMD_RST;
                next_cyc_time = ETSF_CYC_RST;
                next_sync_time = ETSF_SYNC_RST;
            end else begin
                next_tx_state = ETSF_TX_HOLD;
                next_tx_id = eff_id[ETSF_IX_PREP];
                next_tx_dlc = ETSF_DLC_PREP; // RULE3 RULE6
                next_tx_data = {48'h0, status_byte, function_select}; // RULE4
            end
        end else if (cyc_due && tx_state == ETSF_TX_IDLE) begin
            // Cyclic report yields to replies
            cyc_take = 1'b1;
            next_tx_state = ETSF_TX_HOLD;
            next_tx_id = eff_id[ETSF_IX_CYC];
            next_tx_dlc = ETSF_DLC_POS; // RULE6
            next_tx_data = {16'h0000, position, status_byte, ETSF_FSC_CYC}; // RULE4 RULE17
        end
    end

    // Framer registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state <= ETSF_TX_IDLE;
            tx_id <= 11'h000;
            tx_dlc <= 4'h0;
            tx_data <= 64'h0;
            cmd <= ETSF_CMD_RST;
            cyc_time <= ETSF_CYC_RST;
            sync_time <= ETSF_SYNC_RST;
            id_val <= '{default: 11'h000};
            id_def <= 6'h00;
            loaded <= 1'b0;
            nv_we <= 1'b0;
            nv_index <= 3'h0;
            nv_value <= 11'h000;
        end else begin
            tx_state <= next_tx_state;
            tx_id <= next_tx_id;
            tx_dlc <= next_tx_dlc;
            tx_data <= next_tx_data;
            cmd <= next_cmd;
            cyc_time <= next_cyc_time;
            sync_time <= next_sync_time;
            id_val <= next_id_val;
            id_def <= next_id_def;
            loaded <= 1'b1;
            nv_we <= next_nv_we;
            nv_index <= next_nv_index;
            nv_value <= next_nv_value;
        end
    end

    assign tx_valid = (tx_state == ETSF_TX_HOLD);

    // Ms divider, cycle and sync timers; sync realigns the ms grid
    always_comb begin
        ms_tick = (ms_cnt == ETSF_MS_W'(MS_CYCLES - 1));
        next_ms_cnt = (ms_tick || sync_rx) ? '0 : ms_cnt + 1'b1;
        cyc_tick = running && ms_tick && (cyc_cnt + 16'h0001 >= cyc_time);
        sync_to = running && cmd[ETSF_CMD_SYNC] && ms_tick
                  && (sync_cnt + 16'h0001 >= sync_time); // RULE16
        next_cyc_cnt = cyc_cnt;
        if (!running || cyc_tick) begin
            next_cyc_cnt = 16'h0000;
        end else if (ms_tick) begin
            next_cyc_cnt = cyc_cnt + 16'h0001;
        end
        next_sync_cnt = sync_cnt;
        if (!running || sync_rx || sync_to) begin
            next_sync_cnt = 16'h0000;
        end else if (ms_tick) begin
            next_sync_cnt = sync_cnt + 16'h0001;
        end
        // Sync mode waits for a sync before reporting
        next_running = running;
        if (sw_reset || !cmd[ETSF_CMD_CYCLIC] || sync_to) begin
            next_running = 1'b0; // RULE16
        end else if (!running && (!cmd[ETSF_CMD_SYNC] || sync_rx)) begin
            next_running = 1'b1;
        end
        next_cyc_due = running && ((cyc_due && !cyc_take) || cyc_tick);
    end

    // Timer registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ms_cnt <= '0;
            cyc_cnt <= 16'h0000;
            sync_cnt <= 16'h0000;
            running <= 1'b0;
            cyc_due <= 1'b0;
        end else begin
            ms_cnt <= next_ms_cnt;
            cyc_cnt <= next_cyc_cnt;
            sync_cnt <= next_sync_cnt;
            running <= next_running;
            cyc_due <= next_cyc_due;
        end
    end

    // Status byte; controller error is both event and live cause
    etsf_status u_status (
        .clk(clk),
        .rst(rst),
        .err_set({sync_to, err_par, err_pos, can_error}), // RULE19
        .err_hold({3'h0, can_error}), // RULE11
        .err_clear(err_clear),
        .busy_cause(position_fault), // RULE8
        .fallback(fallback),
        .periodic(running), // RULE13
        .sync_on(cmd[ETSF_CMD_SYNC]),
        .status_byte(status_byte)
    );

    // Read mux; data only in the cycle after the strobe
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_re) begin
            case (reg_addr)
                ETSF_REG_STATUS: next_rdata = {24'h000000, status_byte};
                ETSF_REG_CTRL: next_rdata = {23'h000000, running, cmd};
                ETSF_REG_CYC: next_rdata = {16'h0000, cyc_time};
                ETSF_REG_SYNC: next_rdata = {16'h0000, sync_time};
                default: next_rdata = 32'h0000_0000; // Unmapped reads zero
            endcase
            for (int i = 0; i < ETSF_NUM_ID; i++) begin
                if (reg_addr == id_addr(i)) begin
                    next_rdata = {20'h00000, id_def[i], eff_id[i]};
                end
            end
        end
    end

    // Read data register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_pos_reply: assert property ( // RULE4
        hit_req && function_select == ETSF_FSC_POS |=> tx_valid && tx_dlc == ETSF_DLC_POS
        && tx_data[15:8] == $past(status_byte) && tx_data[47:16] == $past(position))
        else $error("Position reply malformed");
    a_no_padding: assert property ( // RULE6
        tx_valid && tx_dlc == ETSF_DLC_PREP |-> tx_data[63:16] == 48'h0)
        else $error("Parameter reply carries padding");
    a_tx_holds: assert property ( // RULE3
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_dlc))
        else $error("Pending frame changed before taken");
    a_busy_set: assert property ( // RULE8
        position_fault |=> status_byte[7])
        else $error("Busy not set on position fault");
    a_com_clear: assert property ( // RULE10
        hit_par && function_select == ETSF_FSC_READ && !can_error |=> !status_byte[3])
        else $error("Com error kept after read status");
    a_com_sticky: assert property ( // RULE19
        can_error |=> status_byte[3])
        else $error("Com error not set by controller error");
    a_id_default: assert property ( // RULE18
        hit_req && function_select == ETSF_FSC_POS && !id_def[ETSF_IX_REP]
        |=> tx_id == ETSF_ID_DEF[ETSF_IX_REP])
        else $error("Reply not on default identifier");
    a_sync_stop: assert property ( // RULE16
        sync_to |=> !running && status_byte[6] ##1 !cyc_due)
        else $error("Sync timeout did not stop reporting");
    a_cyc_flag: assert property ( // RULE13
        $rose(running) |=> status_byte[1])
        else $error("Cyclic flag missing while reporting");
    c_pos_reply: cover property (hit_req ##1 tx_valid ##[1:4] tx_ready);
    c_cyclic: cover property (cyc_take);
    c_sync_to: cover property (sync_to);
    c_long_frame: cover property (hit_req && rx_dlc == 4'h8);
endmodule // etsf_framer

// ### tb/etsf_partner.sv
// Far-side bus master model: takes outgoing frames, fast or stalling
`timescale 1ns/1ps
module etsf_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow, // Stall every other cycle
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [10:0] tx_id,
    input wire logic [3:0] tx_dlc,
    input wire logic [63:0] tx_data,
    output logic [10:0] got_id, // Last frame taken
    output logic [3:0] got_dlc,
    output logic [63:0] got_data,
    output logic [7:0] got_n // Frames taken so far
);
    logic ph; // Stall phase, flips each cycle
    // Ready only on open phase when stalling
    assign tx_ready = tx_valid & (~slow | ph);
    // Capture whole frame at the taking edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph <= 1'b0;
            got_n <= 8'h00;
        end else begin
            ph <= ~ph;
            if (tx_valid && tx_ready) begin
                got_id <= tx_id;
                got_dlc <= tx_dlc;
                got_data <= tx_data;
                got_n <= got_n + 8'h01;
            end
        end
    end
endmodule // etsf_partner

// ### tb/tb_top.sv
// Self-checking bench for the telegram framer
`timescale 1ns/1ps
module tb_top;
    import etsf_pkg::*;
    logic clk = 0, rst = 1, reg_we = 0, reg_re = 0, rx_valid = 0, slow = 0;
    logic position_fault = 0, can_error = 0, default_baud = 1;
    logic [7:0] reg_addr = 8'h00, status_byte, n0, got_n;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, position = 32'h8765_4321;
    logic [10:0] rx_id = 11'h0, tx_id, got_id, nv_value;
    logic [3:0] rx_dlc = 4'h0, tx_dlc, got_dlc;
    logic [63:0] rx_data = 64'h0, tx_data, got_data;
    logic rx_ready, tx_valid, tx_ready, nv_we;
    logic [2:0] nv_index;
    int fail_count = 0, checks_done = 0;
    etsf_framer #(.MS_CYCLES(10)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_id(rx_id), .rx_dlc(rx_dlc),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
        .tx_dlc(tx_dlc), .tx_data(tx_data), .position(position),
        .position_fault(position_fault), .can_error(can_error),
        .default_baud(default_baud), .nv_id(66'h0), .nv_defined(6'h00), .nv_we(nv_we),
        .nv_index(nv_index), .nv_value(nv_value), .status_byte(status_byte));
    etsf_partner p (.clk(clk), .rst(rst), .slow(slow), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data),
        .got_id(got_id), .got_dlc(got_dlc), .got_data(got_data), .got_n(got_n));
    // Clock at 4 ns period
    initial forever #2 clk = ~clk;
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hold frame until taken, then release after that edge
    task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
        n0 = got_n;
        @(posedge clk);
        rx_id <= id; rx_dlc <= dlc; rx_data <= d; rx_valid <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            @(negedge clk);
            if (rx_ready === 1'b1) break;
        end
        @(posedge clk) rx_valid <= 1'b0;
    endtask
    // Bounded wait for the next frame, then compare all fields
    task automatic expect_tx(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
        for (int i = 0; i < 200 && got_n === n0; i++) @(negedge clk);
        chk({63'h0, got_n !== n0}, 64'h1);
        chk({53'h0, got_id}, {53'h0, id});
        chk({60'h0, got_dlc}, {60'h0, dlc});
        chk(got_data, d);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_we <= 1'b1; end
        @(posedge clk) reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk) begin reg_addr <= a; reg_re <= 1'b1; end
        @(posedge clk) reg_re <= 1'b0;
        @(negedge clk) chk({32'h0, reg_rdata}, {32'h0, e});
    endtask
    task automatic st(input logic [7:0] e);
        repeat (3) @(posedge clk);
        @(negedge clk) chk({56'h0, status_byte}, {56'h0, e});
    endtask
    // Long request with surplus bytes, reply low byte first
    task automatic t_pos();
        send(11'h200, 4'h8, {56'hdead_beef_aa55_cc, ETSF_FSC_POS});
        expect_tx(11'h280, 4'h6, {16'h0, 32'h8765_4321, 8'h04, 8'h00});
    endtask
    task automatic t_busy();
        @(posedge clk) position_fault <= 1'b1;
        st(8'h84);
        @(posedge clk) position_fault <= 1'b0;
        st(8'h04);
    endtask
    // Bad code, live cause kept, read status clears, slow far side
    task automatic t_err();
        slow <= 1'b1;
        send(11'h200, 4'h1, 64'h05);
        repeat (20) @(negedge clk);
        chk({56'h0, got_n}, {56'h0, n0});
        st(8'h14);
        @(posedge clk) can_error <= 1'b1;
        st(8'h1c);
        send(11'h300, 4'h1, {56'h0, ETSF_FSC_READ});
        expect_tx(11'h380, 4'h2, {48'h0, 8'h1c, 8'h02});
        st(8'h0c);
        @(posedge clk) can_error <= 1'b0;
        send(11'h300, 4'h1, {56'h0, ETSF_FSC_READ});
        expect_tx(11'h380, 4'h2, {48'h0, 8'h0c, 8'h02});
        st(8'h04);
        slow <= 1'b0;
    endtask
    task automatic t_cyc();
        rd(ETSF_REG_STATUS, 32'h04);
        rd(8'h40, 32'h0);
        wr(ETSF_REG_CYC, 32'h1);
        n0 = got_n;
        wr(ETSF_REG_CTRL, 32'h1);
        expect_tx(11'h180, 4'h6, {16'h0, 32'h8765_4321, 8'h06, ETSF_FSC_CYC});
        wr(ETSF_REG_CTRL, 32'h0);
        st(8'h04);
    endtask
    // Identifier write telegram, request on it, then sync timeout
    task automatic t_cfg();
        send(11'h300, 4'h3, {40'h0, 16'h0123, ETSF_FSC_ID0});
        expect_tx(11'h380, 4'h2, {48'h0, 8'h04, ETSF_FSC_ID0});
        chk({50'h0, nv_index, nv_value}, {50'h0, 3'h0, 11'h123});
        send(11'h123, 4'h1, {56'h0, ETSF_FSC_POS});
        expect_tx(11'h280, 4'h6, {16'h0, 32'h8765_4321, 16'h0});
        wr(ETSF_REG_SYNC, 32'h2);
        wr(ETSF_REG_CTRL, 32'h3);
        send(11'h100, 4'h1, 64'h0);
        repeat (60) @(negedge clk);
        chk({56'h0, status_byte}, 64'h41);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_pos();
        t_busy();
        t_err();
        t_cyc();
        t_cfg();
        final_report();
    end
    // Watchdog against a hung handshake
    initial begin
        #200000;
        fail_count++;
        final_report();
    end
endmodule // tb_top
